// *** pkg/ubf_map.svh ***
/*
 constants for the byte fifo parallel port: timing counts and reset values.
 assumes a 25 MHz system clock.
*/
`ifndef UBF_MAP_SVH
`define UBF_MAP_SVH
`define UBF_CLK_HZ 25000000
`define UBF_WAKE_MIN_MS 20
`define UBF_WAKE_CYC ((`UBF_CLK_HZ / 1000) * `UBF_WAKE_MIN_MS)
`define UBF_AUX_SEL_W 2
`define UBF_AUX_TXDEN 2'h0
`define UBF_AUX_POWER_ENABLE_N 2'h1
`define UBF_AUX_SLEEP 2'h2
`define UBF_AUX_DRIVE0 2'h3
`define UBF_BYTE_RST 8'h00
`endif

// *** pkg/ubf_pkg.sv ***
/*
 types for the byte fifo parallel port.
 assumes ubf_map.svh is on the include path.
*/
`include "ubf_map.svh"
package ubf_pkg;
    typedef logic [7:0] ubf_byte_t;
    typedef struct packed {
        logic remote_wake_en;
        logic suspend_pull_down;
        logic [`UBF_AUX_SEL_W-1:0] aux_a_sel;
        logic [`UBF_AUX_SEL_W-1:0] aux_b_sel;
    } ubf_cfg_t;
    typedef struct packed {
        logic wake_req;
        logic flush_req;
    } ubf_usb_req_t;
    typedef enum logic [1:0] {UBF_RUN, UBF_SUSP, UBF_WAKE_DONE} ubf_pwr_t;
endpackage

// *** rtl/ubf_skid.sv ***
/*
 two-entry buffer with valid and ready on both sides.
 assumes one clock and synchronous active-high reset.
*/
`timescale 1ns/100ps
`default_nettype none
module ubf_skid
    import ubf_pkg::*;
#(
    parameter int WIDTH = 8
)
(
    input wire logic clock,
    input wire logic srst,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    logic [WIDTH-1:0] mem_q [2];
    logic [WIDTH-1:0] mem_d [2];
    logic wp_q, wp_d, rp_q, rp_d;
    logic [1:0] cnt_q, cnt_d;
    logic push, pop;

    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;
    assign in_ready = (cnt_q != 2'h2);
    assign out_valid = (cnt_q != 2'h0);
    assign out_data = mem_q[rp_q];

    always_comb
    begin
        mem_d = mem_q;
        wp_d = wp_q;
        rp_d = rp_q;
        cnt_d = cnt_q;
        if (push)
        begin
            mem_d[wp_q] = in_data;
            wp_d = ~wp_q;
        end
        if (pop)
        begin
            rp_d = ~rp_q;
        end
        if (push && !pop)
        begin
            cnt_d = cnt_q + 2'h1;
        end
        else if (pop && !push)
        begin
            cnt_d = cnt_q - 2'h1;
        end
    end

    always_ff @(posedge clock)
    begin
        mem_q <= mem_d;
        if (srst)
        begin
            wp_q <= 1'b0;
            rp_q <= 1'b0;
            cnt_q <= 2'h0;
        end
        else
        begin
            wp_q <= wp_d;
            rp_q <= rp_d;
            cnt_q <= cnt_d;
        end
    end
endmodule
`default_nettype wire

// *** rtl/ubf_fifo.sv ***
/*
 byte fifo holding received or transmit bytes.
 assumes one clock and synchronous active-high reset.
*/
`timescale 1ns/100ps
`default_nettype none
module ubf_fifo
    import ubf_pkg::*;
#(
    parameter int DEPTH = 512,
    parameter int AW = $clog2(DEPTH)
)
(
    input wire logic clock,
    input wire logic srst,
    input wire logic wr_en,
    input wire ubf_byte_t wr_data,
    output logic full,
    input wire logic rd_en,
    output ubf_byte_t rd_data,
    output logic empty,
    output logic [AW:0] level
);
    ubf_byte_t mem [DEPTH];
    logic [AW-1:0] wp_q, wp_d, rp_q, rp_d;
    logic [AW:0] cnt_q, cnt_d;
    logic do_wr, do_rd;

    assign full = (cnt_q == AW'(0) + (AW+1)'(DEPTH));
    assign empty = (cnt_q == '0);
    assign level = cnt_q;
    assign rd_data = mem[rp_q];
    assign do_wr = wr_en && !full;
    assign do_rd = rd_en && !empty;

    always_comb
    begin
        wp_d = do_wr ? wp_q + AW'(1) : wp_q;
        rp_d = do_rd ? rp_q + AW'(1) : rp_q;
        cnt_d = cnt_q;
        if (do_wr && !do_rd)
        begin
            cnt_d = cnt_q + (AW+1)'(1);
        end
        else if (do_rd && !do_wr)
        begin
            cnt_d = cnt_q - (AW+1)'(1);
        end
    end

    always_ff @(posedge clock)
    begin
        if (do_wr)
        begin
            mem[wp_q] <= wr_data;
        end
        if (srst)
        begin
            wp_q <= '0;
            rp_q <= '0;
            cnt_q <= '0;
        end
        else
        begin
            wp_q <= wp_d;
            rp_q <= rp_d;
            cnt_q <= cnt_d;
        end
    end
endmodule
`default_nettype wire

// *** rtl/ubf_port.sv ***
/*
 parallel byte fifo port: strobed read and write toward an external controller,
 byte streams toward the usb engine, suspend, wake and auxiliary pin logic.
 assumes strobes are synchronous to clock and reset_n is the pin, already sampled.
*/
//
// Contract
// - drive current receive byte onto byte_bus while read strobe is low, else release
// - each falling read strobe advances to next receive byte if one is available
// - each falling write strobe captures byte_bus into the transmit buffer if it is not full
// - space flag high when transmit buffer is full, low when a write may be made
// - data flag low when receive buffer holds data; controller reads only then
// - during reset both flag outputs are released to high impedance
// - during usb suspend the power-enable indicator is driven to one; an aux pin set to UBF_AUX_POWER_ENABLE_N is driven to zero instead
// - with remote wakeup enabled, data flag pin turns input during suspend
// - data pin held low at least 20 ms in suspend requests usb resume
// - send-now low flushes transmit data; when suspended it requests wakeup
// - reset pin low resets the device; high keeps it running
// - configured option selects pull-down instead of pull-up during suspend
// - auxiliary pin functions come from the nonvolatile configuration store
`timescale 1ns/100ps
`default_nettype none
`include "ubf_map.svh"
module ubf_port
    import ubf_pkg::*;
#(
    parameter int RX_DEPTH = 512,
    parameter int TX_DEPTH = 512,
    parameter int WAKE_CYC = `UBF_WAKE_CYC
)
(
    input wire logic clock,
    input wire logic srst,
    input wire logic reset_n,
    input wire ubf_byte_t byte_bus_i,
    output ubf_byte_t byte_bus_o,
    output logic byte_bus_oe,
    input wire logic read_strobe_n,
    input wire logic write_strobe,
    output logic tx_space_avail_n,
    output logic tx_space_avail_oe,
    input wire logic rx_data_avail_i,
    output logic rx_data_avail_n,
    output logic rx_data_avail_oe,
    input wire logic send_now_wake_n,
    output logic power_enable_n,
    output logic pins_pull_down,
    output logic aux_cfg_pin_a,
    output logic aux_cfg_pin_b,
    input wire ubf_cfg_t nonvolatile_config_store,
    input wire logic usb_suspend,
    input wire logic usb_rx_valid,
    output logic usb_rx_ready,
    input wire ubf_byte_t usb_rx_data,
    output logic usb_tx_valid,
    input wire logic usb_tx_ready,
    output ubf_byte_t usb_tx_data,
    output ubf_usb_req_t usb_req
);
    localparam int RAW = $clog2(RX_DEPTH);
    localparam int TAW = $clog2(TX_DEPTH);
    localparam int WCW = $clog2(WAKE_CYC + 1);

    logic rst;
    logic rdy_q, rdy_d;
    logic rx_full, rx_empty, tx_full, tx_empty;
    logic rx_pop, tx_push, tx_pop;
    ubf_byte_t rx_head, tx_head;
    logic [RAW:0] rx_level;
    logic [TAW:0] tx_level;
    logic skid_valid, skid_ready;
    ubf_byte_t skid_data;

    logic rd_q, rd_d, wr_q, wr_d, send_now_wake_n_q, send_now_wake_n_d;
    ubf_byte_t bus_q, bus_d;
    logic bus_oe_q, bus_oe_d;
    logic txe_q, txe_d, txe_oe_q, txe_oe_d;
    logic rxf_q, rxf_d, rxf_oe_q, rxf_oe_d;
    logic pwr_q, pwr_d, pull_q, pull_d;
    logic aux_q [2];
    logic aux_d [2];
    logic [`UBF_AUX_SEL_W-1:0] aux_sel [2];
    ubf_usb_req_t req_q, req_d;
    ubf_pwr_t pst_q, pst_d;
    logic [WCW-1:0] wcnt_q, wcnt_d;
    logic read_fall, write_fall, send_now_wake_n_fall, wake_pin;

    assign rst = srst || !reset_n;

    // receive path, usb side filling in order
    ubf_fifo #(.DEPTH(RX_DEPTH)) u_rx (
        .clock(clock),
        .srst(rst),
        .wr_en(usb_rx_valid && rdy_q),
        .wr_data(usb_rx_data),
        .full(rx_full),
        .rd_en(rx_pop),
        .rd_data(rx_head),
        .empty(rx_empty),
        .level(rx_level)
    );
    assign usb_rx_ready = rdy_q;

    // transmit path, drained through the skid buffer
    ubf_fifo #(.DEPTH(TX_DEPTH)) u_tx (
        .clock(clock),
        .srst(rst),
        .wr_en(tx_push),
        .wr_data(byte_bus_i),
        .full(tx_full),
        .rd_en(tx_pop),
        .rd_data(tx_head),
        .empty(tx_empty),
        .level(tx_level)
    );
    assign tx_pop = !tx_empty && skid_ready;

    ubf_skid #(.WIDTH(8)) u_skid (
        .clock(clock),
        .srst(rst),
        .in_valid(!tx_empty),
        .in_ready(skid_ready),
        .in_data(tx_head),
        .out_valid(skid_valid),
        .out_ready(usb_tx_ready && !usb_suspend),
        .out_data(skid_data)
    );
    assign usb_tx_valid = skid_valid && !usb_suspend;
    assign usb_tx_data = skid_data;

    // strobe edge detection
    assign read_fall = rd_q && !read_strobe_n;
    assign write_fall = wr_q && !write_strobe;
    assign send_now_wake_n_fall = send_now_wake_n_q && !send_now_wake_n;
    assign rx_pop = read_fall && !rx_empty;
    assign tx_push = write_fall && !tx_full;
    assign wake_pin = nonvolatile_config_store.remote_wake_en && usb_suspend;

    always_comb
    begin
        rd_d = read_strobe_n;
        wr_d = write_strobe;
        send_now_wake_n_d = send_now_wake_n;
        bus_oe_d = !read_strobe_n;
        bus_d = rx_pop ? rx_head : bus_q;
        if (!bus_oe_q && !read_strobe_n)
        begin
            bus_d = rx_head;
        end
        txe_d = tx_full || (tx_push && tx_level == (TAW+1)'(TX_DEPTH - 1));
        txe_oe_d = 1'b1;
        rxf_d = rx_empty || (rx_pop && rx_level == (RAW+1)'(1));
        rxf_oe_d = !wake_pin;
        pwr_d = usb_suspend;
        pull_d = usb_suspend && nonvolatile_config_store.suspend_pull_down;
        rdy_d = !rx_full && (rx_level < (RAW+1)'(RX_DEPTH - 1));
    end

    // wake and request state
    always_comb
    begin
        req_d = '0;
        req_d.flush_req = send_now_wake_n_fall && !usb_suspend;
        pst_d = pst_q;
        wcnt_d = wcnt_q;
        unique case (pst_q)
            UBF_RUN:
            begin
                wcnt_d = '0;
                if (usb_suspend)
                begin
                    pst_d = UBF_SUSP;
                end
            end
            UBF_SUSP:
            begin
                if (!usb_suspend)
                begin
                    pst_d = UBF_RUN;
                end
                else if (send_now_wake_n_fall)
                begin
                    req_d.wake_req = 1'b1;
                    pst_d = UBF_WAKE_DONE;
                end
                else if (wake_pin && !rx_data_avail_i)
                begin
                    wcnt_d = wcnt_q + WCW'(1);
                    if (wcnt_q == WCW'(WAKE_CYC - 1))
                    begin
                        req_d.wake_req = 1'b1;
                        pst_d = UBF_WAKE_DONE;
                    end
                end
                else
                begin
                    wcnt_d = '0;
                end
            end
            UBF_WAKE_DONE:
            begin
                if (!usb_suspend)
                begin
                    pst_d = UBF_RUN;
                end
                else if (send_now_wake_n_fall)
                begin
                    req_d.wake_req = 1'b1;
                end
                else if (!(wake_pin && !rx_data_avail_i))
                begin
                    pst_d = UBF_SUSP;
                    wcnt_d = '0;
                end
            end
        endcase
    end

    // auxiliary pins, one per configured function
    assign aux_sel[0] = nonvolatile_config_store.aux_a_sel;
    assign aux_sel[1] = nonvolatile_config_store.aux_b_sel;
    for (genvar i = 0; i < 2; i++)
    begin : g_aux
        always_comb
        begin
            unique case (aux_sel[i])
                `UBF_AUX_TXDEN: aux_d[i] = !tx_empty;
                `UBF_AUX_POWER_ENABLE_N: aux_d[i] = !usb_suspend;
                `UBF_AUX_SLEEP: aux_d[i] = usb_suspend;
                `UBF_AUX_DRIVE0: aux_d[i] = 1'b0;
            endcase
        end

        always_ff @(posedge clock)
        begin
            if (rst)
            begin
                aux_q[i] <= 1'b0;
            end
            else
            begin
                aux_q[i] <= aux_d[i];
            end
        end
    end

    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            rd_q <= 1'b1;
            wr_q <= 1'b0;
            send_now_wake_n_q <= 1'b1;
            bus_q <= `UBF_BYTE_RST;
            bus_oe_q <= 1'b0;
            txe_q <= 1'b1;
            txe_oe_q <= 1'b0;
            rxf_q <= 1'b1;
            rxf_oe_q <= 1'b0;
            pwr_q <= 1'b0;
            pull_q <= 1'b0;
            rdy_q <= 1'b0;
        end
        else
        begin
            rd_q <= rd_d;
            wr_q <= wr_d;
            send_now_wake_n_q <= send_now_wake_n_d;
            bus_q <= bus_d;
            bus_oe_q <= bus_oe_d;
            txe_q <= txe_d;
            txe_oe_q <= txe_oe_d;
            rxf_q <= rxf_d;
            rxf_oe_q <= rxf_oe_d;
            pwr_q <= pwr_d;
            pull_q <= pull_d;
            rdy_q <= rdy_d;
        end
    end

    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            req_q <= '0;
            pst_q <= UBF_RUN;
            wcnt_q <= '0;
        end
        else
        begin
            req_q <= req_d;
            pst_q <= pst_d;
            wcnt_q <= wcnt_d;
        end
    end

    assign byte_bus_o = bus_q;
    assign byte_bus_oe = bus_oe_q;
    assign tx_space_avail_n = txe_q;
    assign tx_space_avail_oe = txe_oe_q;
    assign rx_data_avail_n = rxf_q;
    assign rx_data_avail_oe = rxf_oe_q;
    assign power_enable_n = pwr_q;
    assign pins_pull_down = pull_q;
    assign aux_cfg_pin_a = aux_q[0];
    assign aux_cfg_pin_b = aux_q[1];
    assign usb_req = req_q;
endmodule
`default_nettype wire

// *** tb/ubf_port_asserts.sv ***
/*
 concurrent checks on the pins of ubf_port, bound into every instance.
 assumes one clock, srst and reset_n both resetting synchronously.
*/
`timescale 1ns/100ps
`default_nettype none
module ubf_port_asserts
    import ubf_pkg::*;
#(
    parameter int WAKE_CYC = 16
)
(
    input wire logic clock,
    input wire logic srst,
    input wire logic reset_n,
    input wire logic read_strobe_n,
    input wire logic byte_bus_oe,
    input wire logic tx_space_avail_n,
    input wire logic tx_space_avail_oe,
    input wire logic rx_data_avail_i,
    input wire logic rx_data_avail_n,
    input wire logic rx_data_avail_oe,
    input wire logic send_now_wake_n,
    input wire logic power_enable_n,
    input wire logic pins_pull_down,
    input wire ubf_cfg_t nonvolatile_config_store,
    input wire logic usb_suspend,
    input wire logic usb_rx_valid,
    input wire logic usb_rx_ready,
    input wire ubf_usb_req_t usb_req
);
    logic rst;
    logic cond;
    logic [31:0] low_d;
    logic [31:0] low_q;
    default clocking @(posedge clock); endclocking
    default disable iff (rst);
    // counts consecutive cycles of a held wake pin
    always_comb
    begin
        rst = srst || !reset_n;
        cond = usb_suspend && nonvolatile_config_store.remote_wake_en && !rx_data_avail_i;
        low_d = (rst || !cond) ? 32'h0 : low_q + 32'h1;
    end
    always_ff @(posedge clock)
    begin
        low_q <= low_d;
    end
    sequence rd_idle;
        read_strobe_n [*2];
    endsequence
    sequence wake_held;
        cond && (low_q == WAKE_CYC - 1);
    endsequence
    AST_RST_HIZ: assert property (disable iff (1'b0)
        rst |=> !tx_space_avail_oe && !rx_data_avail_oe) else $error("flag pin driven in reset");
    AST_RST_PIN: assert property (disable iff (1'b0)
        !reset_n |=> tx_space_avail_n && rx_data_avail_n) else $error("reset pin ignored");
    AST_BUS_DRIVE: assert property (!read_strobe_n |=> byte_bus_oe)
        else $error("bus not driven during read");
    AST_BUS_FREE: assert property (rd_idle |-> !byte_bus_oe)
        else $error("bus still driven after read");
    AST_SUSP_PWR: assert property (usb_suspend |=> power_enable_n)
        else $error("power indicator low in suspend");
    AST_WAKE_PIN: assert property (
        usb_suspend && nonvolatile_config_store.remote_wake_en |=> !rx_data_avail_oe)
        else $error("data flag pin still driven in suspend");
    AST_PULL_ON: assert property (
        usb_suspend && nonvolatile_config_store.suspend_pull_down |=> pins_pull_down)
        else $error("pull-down missing in suspend");
    AST_PULL_OFF: assert property (!usb_suspend |=> !pins_pull_down)
        else $error("pull-down outside suspend");
    AST_WAKE_REQ: assert property (wake_held |-> ##[0:4] usb_req.wake_req)
        else $error("held wake pin gave no resume");
    AST_FLUSH: assert property ($fell(send_now_wake_n) && !usb_suspend |-> ##[1:4] usb_req.flush_req)
        else $error("send-now gave no flush");
    AST_WAKE_SUSP: assert property (usb_req.wake_req |-> $past(usb_suspend))
        else $error("wake request outside suspend");
    AST_FLUSH_RUN: assert property (usb_req.flush_req |-> !$past(usb_suspend))
        else $error("flush request in suspend");
    AST_RX_FLAG: assert property (usb_rx_valid && usb_rx_ready |-> ##[1:3] !rx_data_avail_n)
        else $error("data flag not low after byte arrived");
endmodule
bind ubf_port ubf_port_asserts #(.WAKE_CYC(WAKE_CYC)) chk_u (.clock(clock), .srst(srst),
    .reset_n(reset_n), .read_strobe_n(read_strobe_n), .byte_bus_oe(byte_bus_oe),
    .tx_space_avail_n(tx_space_avail_n), .tx_space_avail_oe(tx_space_avail_oe),
    .rx_data_avail_i(rx_data_avail_i), .rx_data_avail_n(rx_data_avail_n),
    .rx_data_avail_oe(rx_data_avail_oe), .send_now_wake_n(send_now_wake_n),
    .power_enable_n(power_enable_n), .pins_pull_down(pins_pull_down),
    .nonvolatile_config_store(nonvolatile_config_store), .usb_suspend(usb_suspend),
    .usb_rx_valid(usb_rx_valid), .usb_rx_ready(usb_rx_ready), .usb_req(usb_req));
`default_nettype wire

// *** tb/ubf_ctl_model.sv ***
/*
 external controller model: strobed reads and writes, resolved bus and flag pin.
 assumes it is called at falling clock edges.
*/
`timescale 1ns/100ps
`default_nettype none
module ubf_ctl_model
    import ubf_pkg::*;
(
    input wire logic clock,
    input wire logic wake_low,
    input wire ubf_byte_t byte_bus_o,
    input wire logic byte_bus_oe,
    input wire logic tx_space_avail_n,
    input wire logic rx_data_avail_n,
    input wire logic rx_data_avail_oe,
    input wire logic pins_pull_down,
    output ubf_byte_t byte_bus_i,
    output logic rx_data_avail_i,
    output logic read_strobe_n,
    output logic write_strobe
);
    ubf_byte_t drv = 8'h00;
    logic drv_en = 1'b0;
    initial
    begin
        read_strobe_n = 1'b1;
        write_strobe = 1'b0;
    end
    // released bus shows the inverse of the last byte
    assign byte_bus_i = byte_bus_oe ? byte_bus_o : (drv_en ? drv : ~drv);
    // released flag pin follows the weak pull
    assign rx_data_avail_i = rx_data_avail_oe ? rx_data_avail_n : !(wake_low || pins_pull_down);
    task automatic wr(input ubf_byte_t d);
        int n;
        begin
            n = 0;
            while (tx_space_avail_n !== 1'b0 && n < 100)
            begin
                @(negedge clock);
                n++;
            end
            write_strobe = 1'b1;
            drv = d;
            drv_en = 1'b1;
            @(negedge clock);
            write_strobe = 1'b0;
            @(negedge clock);
            drv_en = 1'b0;
            @(negedge clock);
        end
    endtask
    task automatic rd(output ubf_byte_t d);
        begin
            d = 8'hxx;
            if (rx_data_avail_n === 1'b0)
            begin
                read_strobe_n = 1'b0;
                repeat (2) @(negedge clock);
                d = byte_bus_i;
                read_strobe_n = 1'b1;
                repeat (2) @(negedge clock);
            end
        end
    endtask
endmodule
`default_nettype wire

// *** tb/tb_top.sv ***
/*
 self-checking bench for ubf_port: strobed reads and writes, usb streams, suspend and wake.
 assumes the package, the map header and the controller model are compiled first.
*/
`timescale 1ns/100ps
`default_nettype none
`include "ubf_map.svh"
module tb_top
    import ubf_pkg::*;
;
    localparam int WAKE = 16;
    localparam int TXD = 4;
    logic clock, srst, reset_n, send_now_wake_n, usb_suspend, usb_rx_valid, usb_tx_ready;
    logic wake_low, byte_bus_oe, read_strobe_n, write_strobe, tx_space_avail_n, w, f;
    logic tx_space_avail_oe, rx_data_avail_i, rx_data_avail_n, rx_data_avail_oe;
    logic power_enable_n, pins_pull_down, aux_cfg_pin_a, aux_cfg_pin_b, usb_rx_ready, usb_tx_valid;
    ubf_byte_t byte_bus_i, byte_bus_o, usb_rx_data, usb_tx_data, b;
    ubf_byte_t pat[3] = '{8'h5a, 8'ha5, 8'h3c};
    ubf_byte_t got[$];
    ubf_cfg_t nonvolatile_config_store;
    ubf_usb_req_t usb_req;
    int err_count = 0;
    int checks_done = 0;
    int n, k;
    ubf_port #(.RX_DEPTH(4), .TX_DEPTH(TXD), .WAKE_CYC(WAKE)) dut_u (.clock(clock), .srst(srst),
        .reset_n(reset_n), .byte_bus_i(byte_bus_i), .byte_bus_o(byte_bus_o),
        .byte_bus_oe(byte_bus_oe), .read_strobe_n(read_strobe_n), .write_strobe(write_strobe),
        .tx_space_avail_n(tx_space_avail_n), .tx_space_avail_oe(tx_space_avail_oe),
        .rx_data_avail_i(rx_data_avail_i), .rx_data_avail_n(rx_data_avail_n),
        .rx_data_avail_oe(rx_data_avail_oe), .send_now_wake_n(send_now_wake_n),
        .power_enable_n(power_enable_n), .pins_pull_down(pins_pull_down),
        .aux_cfg_pin_a(aux_cfg_pin_a), .aux_cfg_pin_b(aux_cfg_pin_b),
        .nonvolatile_config_store(nonvolatile_config_store), .usb_suspend(usb_suspend),
        .usb_rx_valid(usb_rx_valid), .usb_rx_ready(usb_rx_ready), .usb_rx_data(usb_rx_data),
        .usb_tx_valid(usb_tx_valid), .usb_tx_ready(usb_tx_ready), .usb_tx_data(usb_tx_data),
        .usb_req(usb_req));
    ubf_ctl_model ctl_u (.clock(clock), .wake_low(wake_low), .byte_bus_o(byte_bus_o),
        .byte_bus_oe(byte_bus_oe), .tx_space_avail_n(tx_space_avail_n),
        .rx_data_avail_n(rx_data_avail_n), .rx_data_avail_oe(rx_data_avail_oe),
        .pins_pull_down(pins_pull_down), .byte_bus_i(byte_bus_i),
        .rx_data_avail_i(rx_data_avail_i), .read_strobe_n(read_strobe_n),
        .write_strobe(write_strobe));
    initial clock = 1'b0;
    always #20 clock = ~clock;
    task check(input logic [7:0] seen, input logic [7:0] exp);
        begin
            checks_done++;
            if (seen !== exp)
            begin
                err_count++;
                $display("wrong value at %0t: saw %h, expected %h", $time, seen, exp);
            end
        end
    endtask
    task conclude;
        begin
            $display("comparisons %0d, mismatches %0d", checks_done, err_count);
            if (err_count == 0 && checks_done > 0)
                $display("All tests passed");
            else
                $display("Some tests failed");
            $finish;
        end
    endtask
    task push(input ubf_byte_t d);
        begin
            usb_rx_valid = 1'b1;
            usb_rx_data = d;
            for (int i = 0; i < 50 && usb_rx_ready !== 1'b1; i++)
                @(negedge clock);
            @(negedge clock);
            usb_rx_valid = 1'b0;
            @(negedge clock);
        end
    endtask
    task watch(input int c);
        begin
            w = 1'b0;
            f = 1'b0;
            repeat (c)
            begin
                @(negedge clock);
                w = w | (usb_req.wake_req === 1'b1);
                f = f | (usb_req.flush_req === 1'b1);
            end
        end
    endtask
    initial
    begin
        repeat (3000) @(posedge clock);
        err_count++;
        conclude();
    end
    initial
    begin
        srst = 1'b1;
        reset_n = 1'b1;
        send_now_wake_n = 1'b1;
        usb_suspend = 1'b0;
        usb_rx_valid = 1'b0;
        usb_rx_data = 8'h00;
        usb_tx_ready = 1'b0;
        wake_low = 1'b0;
        nonvolatile_config_store = '0;
        repeat (3) @(negedge clock);
        check(8'(tx_space_avail_oe || rx_data_avail_oe), 8'h0);
        srst = 1'b0;
        repeat (2) @(negedge clock);
        check(8'({tx_space_avail_oe, tx_space_avail_n, rx_data_avail_n}), 8'h5);
        check(8'(usb_rx_ready), 8'h1);
        reset_n = 1'b0;
        repeat (2) @(negedge clock);
        check(8'(tx_space_avail_oe || rx_data_avail_oe), 8'h0);
        reset_n = 1'b1;
        repeat (2) @(negedge clock);
        for (int i = 0; i < 3; i++)
            push(pat[i]);
        check(8'(rx_data_avail_n), 8'h0);
        for (n = 0; n < 6 && rx_data_avail_n === 1'b0; n++)
        begin
            ctl_u.rd(b);
            got.push_back(b);
        end
        for (int i = 0; i < 3; i++)
            check(got[i], pat[i]);
        check(8'({rx_data_avail_n, byte_bus_oe}), 8'h2);
        for (n = 0; n < 16 && tx_space_avail_n === 1'b0; n++)
            ctl_u.wr(8'h10 + 8'(n));
        check(8'({tx_space_avail_n, n >= TXD}), 8'h3);
        got.delete();
        usb_tx_ready = 1'b1;
        for (k = 0; k < 200 && got.size() < n; k++)
        begin
            if (usb_tx_valid === 1'b1 && usb_tx_ready)
                got.push_back(usb_tx_data);
            @(negedge clock);
            usb_tx_ready = (k % 4) != 3;
        end
        for (int i = 0; i < n; i++)
            check(got[i], 8'h10 + 8'(i));
        usb_tx_ready = 1'b0;
        repeat (2) @(negedge clock);
        check(8'(tx_space_avail_n), 8'h0);
        send_now_wake_n = 1'b0;
        watch(6);
        send_now_wake_n = 1'b1;
        check(8'({w, f}), 8'h1);
        nonvolatile_config_store = {1'b1, 1'b0, `UBF_AUX_SLEEP, `UBF_AUX_POWER_ENABLE_N};
        usb_suspend = 1'b1;
        repeat (3) @(negedge clock);
        check(8'({aux_cfg_pin_a, aux_cfg_pin_b}), 8'h2);
        check(8'({power_enable_n, rx_data_avail_oe}), 8'h2);
        wake_low = 1'b1;
        watch(WAKE - 4);
        check(8'(w), 8'h0);
        watch(10);
        wake_low = 1'b0;
        check(8'(w), 8'h1);
        repeat (2) @(negedge clock);
        send_now_wake_n = 1'b0;
        watch(6);
        send_now_wake_n = 1'b1;
        check(8'({w, f}), 8'h2);
        nonvolatile_config_store = {1'b0, 1'b1, `UBF_AUX_POWER_ENABLE_N, `UBF_AUX_TXDEN};
        repeat (2) @(negedge clock);
        check(8'(pins_pull_down), 8'h1);
        usb_suspend = 1'b0;
        repeat (2) @(negedge clock);
        check(8'(pins_pull_down), 8'h0);
        check(8'({aux_cfg_pin_a, aux_cfg_pin_b}), 8'h2);
        conclude();
    end
endmodule
`default_nettype wire
